// ===== logic/tsi_defines.vh
`ifndef TSI_DEFINES_VH
`define TSI_DEFINES_VH

// clock rates and bit clock chain
`define TSI_REF_CLK_KHZ 250000
`define TSI_OSC_KHZ 440
`define TSI_PRESCALE (`TSI_REF_CLK_KHZ / `TSI_OSC_KHZ)
`define TSI_FIRST_DIVIDE 2'h3
`define TSI_DECADE_LAST 4'h9
`define TSI_DECADE_STAGES 3

// register offsets
`define TSI_ADDR_CTRL 4'h0
`define TSI_ADDR_STATUS 4'h1
`define TSI_ADDR_RXDATA 4'h2
`define TSI_ADDR_CODES 4'h3

// control register fields
`define TSI_CTRL_SOFT_RESET 7

// status register fields
`define TSI_ST_RX_MODE 0
`define TSI_ST_TX_MODE 1
`define TSI_ST_RX_FULL 2
`define TSI_ST_HANDOFF 3
`define TSI_ST_FAULT 4
`define TSI_ST_ERROR 5
`define TSI_ST_TX_RUN 6
`define TSI_ST_RX_RUN 7

// preparation codes, index order is transmit priority
`define TSI_NCODE 8
`define TSI_IDX_READER_ON 0
`define TSI_CODE_READER_ON 8'h11
`define TSI_CODE_PUNCH_ON 8'h12
`define TSI_CODE_PRINTER_ON 8'h0f
`define TSI_CODE_PUNCH_OFF 8'h14
`define TSI_CODE_ENTER 8'h45
`define TSI_CODE_LOAD 8'h4c
`define TSI_CODE_LPAREN 8'h28
`define TSI_CODE_RPAREN 8'h29
`define TSI_SRC_HOST 4'h8

// shift register presets
`define TSI_RX_PRESET 9'h0ff
`define TSI_TX_HIGH_STOPS 3'h4
`define TSI_TX_IDLE 11'h7ff

`endif

// ===== logic/tsi_code_pair.v
`timescale 1ns/10ps
module tsi_code_pair (
	input wire i_ref_clk,
	input wire i_rst,
	input wire i_clear,
	input wire i_start,
	input wire i_taken,
	input wire i_sent,
	output wire o_present,
	output wire o_permit
);
	reg d;
	reg e;

	// 00 idle, 10 code presented, 11 loaded and sent, 01 permit next
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			d <= 1'b0;
			e <= 1'b0;
		end else if (i_clear) begin
			d <= 1'b0; // [R25]
			e <= 1'b0;
		end else begin
			case ({d, e})
				2'b00: begin
					if (i_start) begin
						d <= 1'b1; // [R23]
					end
				end
				2'b10: begin
					if (i_taken) begin
						e <= 1'b1; // [R23]
					end
				end
				2'b11: begin
					if (i_sent) begin
						d <= 1'b0; // [R23]
					end
				end
				default: begin
					e <= 1'b0; // [R23]
				end
			endcase
		end
	end

	assign o_present = d & ~e;
	assign o_permit = ~d & e;
endmodule // tsi_code_pair

// ===== logic/tsi_core.v
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "tsi_defines.vh"
// How it works
// R01: write to reader sets fault, returns status, waits for new instruction
// R02: write control to reader acknowledged without sending; status when requested
// R03: read instruction parity checked; bad parity sets error
// R04: read control to reader sends fault status, then waits again
// R05: normal read waits for empty input register, then sends reader-on
// R06: full input register and data request raise the handoff strobe
// R07: strobe held until request drops, then next character unless status
// R08: status request disconnects register, returns status, waits for instruction
// R09: idle receive register parallel mode, presets ones, stop position zero
// R10: incoming start pulse starts the gated receive bit clock
// R11: first receive clock loads presets and inverted start; one enables shifting
// R12: stop zero at detector: parallel mode, clock stops, strobe raised
// R13: handoff leaves receive register unchanged; receive rearms on next start
// R14: transmit mode is nand of eight character bits and first stop
// R15: character present starts transmit clock; first pulse loads and sends start
// R16: transmit preset zeros both stops, highest position held at one
// R17: ones fill from top; all ones stops clock without reload
// R18: serial output rests at zero after a character
// R19: processor control codes forwarded as ordinary characters
// R20: each preparation code made by its own identical flip-flop pair
// R21: reader-on, punch-on, printer-on, punch-off, enter, load, parens generated
// R22: terminal reader stops only on reader-off read from tape itself
// R23: each pair steps idle, presented, sent, permit next
// R24: bit clock from 440 khz, divide by four and three decades
// R25: synchronous reset returns registers, strobe, pairs and handler to idle
module tsi_core #(
	parameter PRESCALE = `TSI_PRESCALE
) (
	input wire i_ref_clk,
	input wire i_rst,
	input wire [3:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	input wire i_instr_strobe,
	input wire i_instr_reader,
	input wire i_instr_write,
	input wire i_instr_read,
	input wire i_instr_control,
	input wire [6:0] i_instr_code,
	input wire i_instr_parity,
	input wire i_lu_request,
	input wire i_lu_status_req,
	input wire i_tx_valid,
	input wire [7:0] i_tx_holding_lines,
	output reg o_tx_ack,
	output reg o_rx_handoff_strobe,
	output reg [7:0] o_lu_data,
	output reg o_status_strobe,
	output reg o_status_fault,
	output reg o_status_error,
	input wire i_serial_in,
	output reg o_serial_out
);
	localparam S_WAIT = 3'h0;
	localparam S_WCTL = 3'h1;
	localparam S_RD_EMPTY = 3'h2;
	localparam S_RD_ON = 3'h3;
	localparam S_RECV = 3'h4;
	localparam S_HAND = 3'h5;
	localparam S_STATUS = 3'h6;
	localparam NC = `TSI_NCODE;

	reg [2:0] state;
	reg fault;
	reg error;
	reg [9:0] pre_cnt;
	reg [1:0] div4;
	reg [9:0] rx_shift_register;
	reg rx_shift_mode;
	reg rx_run;
	reg rx_full;
	reg [10:0] tx_reg;
	reg tx_run;
	reg [7:0] tx_char;
	reg [3:0] tx_src;
	reg reader_on_req;
	reg [3:0] next_sel;
	reg next_any;
	integer k;

	wire soft_clr;
	wire pre_wrap;
	wire [`TSI_DECADE_STAGES:0] carry;
	wire bit_tick;
	wire rx_tick;
	wire tx_tick;
	wire tx_shift_mode;
	wire [10:0] tx_next;
	wire [9:0] rx_next;
	wire [NC-1:0] code_present;
	wire [NC-1:0] code_permit;
	wire [NC-1:0] code_start;
	wire [NC-1:0] code_taken;
	wire [NC-1:0] code_sent;
	wire [8*NC-1:0] code_table;
	wire tx_begin;
	wire tx_done;
	wire instr_bad_parity;

	assign soft_clr = i_wr && (i_addr == `TSI_ADDR_CTRL) && i_wdata[`TSI_CTRL_SOFT_RESET];
	assign code_table = {`TSI_CODE_RPAREN, `TSI_CODE_LPAREN, `TSI_CODE_LOAD, `TSI_CODE_ENTER,
		`TSI_CODE_PUNCH_OFF, `TSI_CODE_PRINTER_ON, `TSI_CODE_PUNCH_ON, `TSI_CODE_READER_ON}; // [R21]

	// bit clock chain
	assign pre_wrap = (pre_cnt == PRESCALE[9:0] - 10'h001);
	assign carry[0] = pre_wrap && (div4 == `TSI_FIRST_DIVIDE); // [R24]

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pre_cnt <= 10'h000;
			div4 <= 2'h0;
		end else begin
			pre_cnt <= pre_wrap ? 10'h000 : pre_cnt + 10'h001;
			if (pre_wrap) begin
				div4 <= div4 + 2'h1; // [R24]
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < `TSI_DECADE_STAGES; g = g + 1) begin : g_decade
			reg [3:0] dec;
			assign carry[g+1] = carry[g] && (dec == `TSI_DECADE_LAST);
			always @(posedge i_ref_clk or posedge i_rst) begin
				if (i_rst) begin
					dec <= 4'h0;
				end else if (carry[g]) begin
					dec <= (dec == `TSI_DECADE_LAST) ? 4'h0 : dec + 4'h1; // [R24]
				end
			end
		end
	endgenerate

	assign bit_tick = carry[`TSI_DECADE_STAGES];
	assign rx_tick = bit_tick & rx_run; // [R24]
	assign tx_tick = bit_tick & tx_run; // [R24]

	// receive path
	assign rx_next = {i_serial_in, rx_shift_register[9:1]};

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_shift_register <= {`TSI_RX_PRESET, 1'b0};
			rx_shift_mode <= 1'b0;
			rx_run <= 1'b0;
			rx_full <= 1'b0;
		end else if (soft_clr) begin
			rx_shift_mode <= 1'b0; // [R25]
			rx_run <= 1'b0;
			rx_full <= 1'b0;
		end else begin
			if (!rx_run && !rx_full && !i_serial_in) begin
				rx_run <= 1'b1; // [R10] [R13]
			end else if (rx_tick && !rx_shift_mode) begin
				rx_shift_register <= {`TSI_RX_PRESET, ~i_serial_in}; // [R09] [R11]
				rx_shift_mode <= ~i_serial_in; // [R11]
				rx_run <= ~i_serial_in;
			end else if (rx_tick) begin
				rx_shift_register <= rx_next;
				if (!rx_next[0]) begin
					rx_shift_mode <= 1'b0; // [R12]
					rx_run <= 1'b0; // [R12]
					rx_full <= 1'b1;
				end
			end
			if (state == S_HAND && !i_lu_request) begin
				rx_full <= 1'b0; // [R13]
			end
		end
	end

	// transmit path
	assign tx_shift_mode = ~&tx_reg[8:0]; // [R14]
	assign tx_next = {1'b1, tx_reg[10:1]}; // [R17]
	assign tx_done = tx_tick && tx_shift_mode && (&tx_next[8:0]);
	assign tx_begin = !tx_run && (next_any || (i_tx_valid && !o_tx_ack && state != S_WCTL));

	always @* begin
		next_any = 1'b0;
		next_sel = `TSI_SRC_HOST;
		for (k = NC - 1; k >= 0; k = k - 1) begin
			if (code_present[k]) begin
				next_any = 1'b1;
				next_sel = k[3:0];
			end
		end
	end

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_reg <= `TSI_TX_IDLE;
			tx_run <= 1'b0;
			tx_char <= 8'h00;
			tx_src <= `TSI_SRC_HOST;
			o_serial_out <= 1'b0;
		end else if (soft_clr) begin
			tx_reg <= `TSI_TX_IDLE; // [R25]
			tx_run <= 1'b0;
			o_serial_out <= 1'b0;
		end else begin
			if (tx_begin) begin
				tx_run <= 1'b1; // [R15]
				tx_src <= next_sel;
				tx_char <= next_any ? code_table[8*next_sel +: 8] : i_tx_holding_lines; // [R19]
			end else if (tx_tick && !tx_shift_mode) begin
				tx_reg <= {`TSI_TX_HIGH_STOPS, tx_char}; // [R15] [R16]
				o_serial_out <= 1'b1; // [R15]
			end else if (tx_tick) begin
				tx_reg <= tx_next; // [R17]
				o_serial_out <= tx_reg[0]; // [R18]
				if (&tx_next[8:0]) begin
					tx_run <= 1'b0; // [R17]
				end
			end
		end
	end

	// preparation code pairs
	generate
		for (g = 0; g < NC; g = g + 1) begin : g_code
			assign code_taken[g] = tx_begin && next_any && (next_sel == g);
			assign code_sent[g] = tx_done && (tx_src == g);
			assign code_start[g] = (i_wr && i_wdata[g] && ((i_addr == `TSI_ADDR_CODES) ||
				((i_addr == `TSI_ADDR_CTRL) && (g != `TSI_CTRL_SOFT_RESET)))) ||
				((g == `TSI_IDX_READER_ON) && reader_on_req); // [R21]
			tsi_code_pair i_tsi_code_pair ( // [R20]
				.i_ref_clk(i_ref_clk),
				.i_rst(i_rst),
				.i_clear(soft_clr),
				.i_start(code_start[g]),
				.i_taken(code_taken[g]),
				.i_sent(code_sent[g]),
				.o_present(code_present[g]),
				.o_permit(code_permit[g])
			);
		end
	endgenerate

	// instruction handler for the reader
	assign instr_bad_parity = ~^{i_instr_code, i_instr_parity};

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= S_WAIT;
			fault <= 1'b0;
			error <= 1'b0;
			reader_on_req <= 1'b0;
			o_tx_ack <= 1'b0;
			o_rx_handoff_strobe <= 1'b0;
			o_lu_data <= 8'h00;
			o_status_strobe <= 1'b0;
			o_status_fault <= 1'b0;
			o_status_error <= 1'b0;
		end else if (soft_clr) begin
			state <= S_WAIT; // [R25]
			fault <= 1'b0;
			error <= 1'b0;
			reader_on_req <= 1'b0;
			o_tx_ack <= 1'b0;
			o_rx_handoff_strobe <= 1'b0; // [R25]
			o_status_strobe <= 1'b0;
		end else begin
			reader_on_req <= 1'b0;
			o_status_strobe <= 1'b0;
			o_tx_ack <= tx_done && (tx_src == `TSI_SRC_HOST); // [R19]
			case (state)
				S_WAIT: begin
					if (i_instr_strobe && i_instr_reader) begin
						fault <= 1'b0;
						error <= 1'b0;
						if (i_instr_write && !i_instr_control) begin
							fault <= 1'b1; // [R01]
							state <= S_STATUS;
						end else if (i_instr_write) begin
							state <= S_WCTL; // [R02]
						end else if (i_instr_read) begin
							error <= instr_bad_parity; // [R03]
							if (i_instr_control) begin
								fault <= 1'b1; // [R04]
								state <= S_STATUS;
							end else begin
								state <= S_RD_EMPTY;
							end
						end
					end
				end
				S_WCTL: begin
					if (i_lu_status_req) begin
						state <= S_STATUS; // [R02]
					end else if (i_tx_valid && !o_tx_ack) begin
						o_tx_ack <= 1'b1; // [R02]
					end
				end
				S_RD_EMPTY: begin
					if (!rx_full && !rx_run) begin
						reader_on_req <= 1'b1; // [R05]
						state <= S_RD_ON;
					end
				end
				S_RD_ON: begin
					if (code_permit[`TSI_IDX_READER_ON]) begin
						state <= S_RECV; // [R05]
					end
				end
				S_RECV: begin
					if (i_lu_status_req) begin
						state <= S_STATUS; // [R08]
					end else if (rx_full && i_lu_request) begin
						o_rx_handoff_strobe <= 1'b1; // [R06] [R12]
						o_lu_data <= rx_shift_register[8:1]; // [R06]
						state <= S_HAND;
					end
				end
				S_HAND: begin
					if (!i_lu_request) begin
						o_rx_handoff_strobe <= 1'b0; // [R07]
						state <= S_RECV; // [R07]
					end
				end
				S_STATUS: begin
					o_status_strobe <= 1'b1; // [R08]
					o_status_fault <= fault;
					o_status_error <= error;
					state <= S_WAIT; // [R08]
				end
				default: begin
					state <= S_WAIT;
				end
			endcase
		end
	end

	// register read port
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			if (i_addr == `TSI_ADDR_STATUS) begin
				o_rdata <= {rx_run, tx_run, error, fault, o_rx_handoff_strobe, rx_full, tx_shift_mode, rx_shift_mode};
			end else if (i_addr == `TSI_ADDR_RXDATA) begin
				o_rdata <= rx_shift_register[8:1];
			end else if (i_addr == `TSI_ADDR_CODES) begin
				o_rdata <= code_present;
			end else begin
				o_rdata <= 8'h00;
			end
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule // tsi_core

// ===== dv/tsi_core_checker.sv
`timescale 1ns/10ps
module tsi_core_checker #(
	parameter PRESCALE = 568
) (
	input wire i_ref_clk,
	input wire i_rst,
	input wire [3:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] o_rdata,
	input wire i_instr_strobe,
	input wire i_instr_reader,
	input wire i_instr_write,
	input wire i_instr_read,
	input wire i_instr_control,
	input wire i_lu_request,
	input wire o_rx_handoff_strobe,
	input wire [7:0] o_lu_data,
	input wire o_status_strobe,
	input wire o_status_fault,
	input wire o_serial_out
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	property p_hold; o_rx_handoff_strobe && i_lu_request |=> o_rx_handoff_strobe; endproperty
	a_hold: assert property (p_hold) else $error("handoff dropped early");
	property p_drop; o_rx_handoff_strobe && !i_lu_request |=> !o_rx_handoff_strobe; endproperty
	a_drop: assert property (p_drop) else $error("handoff kept after request left");
	property p_rise; $rose(o_rx_handoff_strobe) |-> $past(i_lu_request); endproperty
	a_rise: assert property (p_rise) else $error("handoff without request");
	property p_keep; o_rx_handoff_strobe ##1 o_rx_handoff_strobe |-> $stable(o_lu_data); endproperty
	a_keep: assert property (p_keep) else $error("data changed during handoff");
	property p_stat; o_status_strobe |=> !o_status_strobe; endproperty
	a_stat: assert property (p_stat) else $error("status pulse too long");
	property p_wflt;
		i_instr_strobe && i_instr_reader && i_instr_write && !i_instr_control |-> ##[1:4] (o_status_strobe && o_status_fault);
	endproperty
	a_wflt: assert property (p_wflt) else $error("write gave no fault status");
	property p_rflt;
		i_instr_strobe && i_instr_reader && i_instr_read && i_instr_control |-> ##[1:4] (o_status_strobe && o_status_fault);
	endproperty
	a_rflt: assert property (p_rflt) else $error("read control gave no fault");
	property p_soft; i_wr && i_addr == 4'h0 && i_wdata[7] |=> !o_rx_handoff_strobe && !o_serial_out; endproperty
	a_soft: assert property (p_soft) else $error("soft reset left outputs");
	property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data outside read");
	property p_unmap; i_rd && i_addr > 4'h3 |=> o_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	c_hand: cover property ($rose(o_rx_handoff_strobe));
	c_fault: cover property (o_status_strobe && o_status_fault);
	c_soft: cover property (i_wr && i_addr == 4'h0 && i_wdata[7]);
endmodule // tsi_core_checker

bind tsi_core tsi_core_checker #(.PRESCALE(PRESCALE)) i_tsi_core_checker (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_instr_strobe(i_instr_strobe), .i_instr_reader(i_instr_reader), .i_instr_write(i_instr_write),
	.i_instr_read(i_instr_read), .i_instr_control(i_instr_control), .i_lu_request(i_lu_request),
	.o_rx_handoff_strobe(o_rx_handoff_strobe), .o_lu_data(o_lu_data), .o_status_strobe(o_status_strobe),
	.o_status_fault(o_status_fault), .o_serial_out(o_serial_out));

// ===== dv/tsi_term_model.sv
`timescale 1ns/10ps
module tsi_term_model #(
	parameter BIT_CYCLES = 4000
) (
	input wire i_ref_clk,
	input wire i_line_in,
	input wire i_send,
	input wire [7:0] i_send_byte,
	output reg o_line_out,
	output reg [7:0] o_got_byte,
	output reg o_got_bad,
	output reg [7:0] o_got_count
);
	integer j;
	integer k;
	reg [7:0] tx;
	reg [7:0] sh;
	initial begin
		o_line_out = 1'b1;
		o_got_byte = 8'h00;
		o_got_bad = 1'b0;
		o_got_count = 8'h00;
	end
	// keyboard side: start low, data lsb first, stop mark high for two bits
	always begin
		@(posedge i_ref_clk);
		if (i_send) begin
			tx = i_send_byte;
			o_line_out <= 1'b0;
			for (j = 0; j < 8; j = j + 1) begin
				repeat (BIT_CYCLES) @(posedge i_ref_clk);
				o_line_out <= tx[j];
			end
			repeat (BIT_CYCLES) @(posedge i_ref_clk);
			o_line_out <= 1'b1;
			repeat (2 * BIT_CYCLES) @(posedge i_ref_clk);
		end
	end
	// printer side decoder: start high, eight data bits lsb first, two stop bits low
	always begin
		@(posedge i_ref_clk);
		if (i_line_in === 1'b1) begin
			repeat (BIT_CYCLES / 2) @(posedge i_ref_clk);
			o_got_bad <= o_got_bad | (i_line_in !== 1'b1);
			for (k = 0; k < 10; k = k + 1) begin
				repeat (BIT_CYCLES) @(posedge i_ref_clk);
				if (k < 8) sh[k] = i_line_in;
				else o_got_bad <= o_got_bad | (i_line_in !== 1'b0);
			end
			o_got_byte <= sh;
			o_got_count <= o_got_count + 8'h01;
		end
	end
endmodule // tsi_term_model

// ===== dv/tb_teletype_serial_interface.sv
`timescale 1ns/10ps
`include "tsi_defines.vh"
module tb_teletype_serial_interface;
	localparam BIT_CYCLES = 4000;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic stb = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic ctl_i = 1'b0;
	logic par = 1'b0;
	logic req = 1'b0;
	logic sreq = 1'b0;
	logic txv = 1'b0;
	logic [7:0] txd = 8'h00;
	logic send = 1'b0;
	wire [7:0] o_rdata;
	wire ack;
	wire hand;
	wire [7:0] lu_data;
	wire sst;
	wire sflt;
	wire serr;
	wire ser_out;
	wire ser_in;
	wire [7:0] got_byte;
	wire got_bad;
	wire [7:0] got_count;
	integer mismatches = 0;
	integer comparisons = 0;
	integer n;
	logic [7:0] v;
	// write, read, control, expected fault
	logic [3:0] rows [0:1] = '{4'b1001, 4'b0111};
	always #2 i_ref_clk = ~i_ref_clk;
	tsi_core #(.PRESCALE(1)) i_tsi_core (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_instr_strobe(stb),
		.i_instr_reader(1'b1), .i_instr_write(wr_i), .i_instr_read(rd_i), .i_instr_control(ctl_i),
		.i_instr_code(7'h01), .i_instr_parity(par), .i_lu_request(req), .i_lu_status_req(sreq),
		.i_tx_valid(txv), .i_tx_holding_lines(txd), .o_tx_ack(ack), .o_rx_handoff_strobe(hand),
		.o_lu_data(lu_data), .o_status_strobe(sst), .o_status_fault(sflt), .o_status_error(serr),
		.i_serial_in(ser_in), .o_serial_out(ser_out));
	tsi_term_model #(.BIT_CYCLES(BIT_CYCLES)) i_tsi_term_model (.i_ref_clk(i_ref_clk), .i_line_in(ser_out),
		.i_send(send), .i_send_byte(8'ha5), .o_line_out(ser_in), .o_got_byte(got_byte),
		.o_got_bad(got_bad), .o_got_count(got_count));
	task wrap_up;
		if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons = comparisons + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task instr(input logic w, input logic r, input logic c, input logic p);
		@(posedge i_ref_clk);
		stb <= 1'b1;
		wr_i <= w;
		rd_i <= r;
		ctl_i <= c;
		par <= p;
		@(posedge i_ref_clk);
		stb <= 1'b0;
	endtask
	task wait_status(input logic ef, input logic ee);
		n = 0;
		while (sst !== 1'b1 && n < 20) begin
			@(posedge i_ref_clk);
			#1 n = n + 1;
		end
		chk("status_strobe", 8'h01, {7'h00, sst});
		chk("status_fault", {7'h00, ef}, {7'h00, sflt});
		chk("status_error", {7'h00, ee}, {7'h00, serr});
	endtask
	initial begin
		repeat (10) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		#1 chk("serial_out", 8'h00, {7'h00, ser_out});
		rd_reg(`TSI_ADDR_STATUS, v);
		chk("status_reg", 8'h00, v);
		rd_reg(4'h9, v);
		chk("unmapped", 8'h00, v);
		for (int i = 0; i < 2; i++) begin
			instr(rows[i][3], rows[i][2], rows[i][1], 1'b0);
			wait_status(rows[i][0], 1'b0);
		end
		instr(1'b1, 1'b0, 1'b1, 1'b0);
		repeat (2) begin
			@(posedge i_ref_clk);
			txv <= 1'b1;
			txd <= 8'h13;
			n = 0;
			while (ack !== 1'b1 && n < 20) begin
				@(posedge i_ref_clk);
				#1 n = n + 1;
			end
			chk("tx_ack", 8'h01, {7'h00, ack});
			@(posedge i_ref_clk);
			txv <= 1'b0;
		end
		@(posedge i_ref_clk);
		sreq <= 1'b1;
		wait_status(1'b0, 1'b0);
		chk("line_quiet", 8'h00, got_count);
		@(posedge i_ref_clk);
		sreq <= 1'b0;
		instr(1'b0, 1'b1, 1'b0, 1'b1);
		n = 0;
		while (got_count !== 8'h01 && n < 60000) begin
			@(posedge i_ref_clk);
			n = n + 1;
		end
		chk("reader_on", `TSI_CODE_READER_ON, got_byte);
		chk("frame", 8'h00, {7'h00, got_bad});
		repeat (BIT_CYCLES) @(posedge i_ref_clk);
		#1 chk("rest_level", 8'h00, {7'h00, ser_out});
		@(posedge i_ref_clk);
		send <= 1'b1;
		@(posedge i_ref_clk);
		send <= 1'b0;
		n = 0;
		v = 8'h00;
		while (v[`TSI_ST_RX_FULL] !== 1'b1 && n < 30000) begin
			rd_reg(`TSI_ADDR_STATUS, v);
			n = n + 1;
		end
		chk("rx_mode", 8'h00, {7'h00, v[`TSI_ST_RX_MODE]});
		chk("early_handoff", 8'h00, {7'h00, hand});
		rd_reg(`TSI_ADDR_RXDATA, v);
		chk("rx_data", 8'ha5, v);
		@(posedge i_ref_clk);
		req <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		#1 chk("handoff", 8'h01, {7'h00, hand});
		chk("lu_data", 8'ha5, lu_data);
		repeat (5) @(posedge i_ref_clk);
		#1 chk("handoff_held", 8'h01, {7'h00, hand});
		rd_reg(`TSI_ADDR_RXDATA, v);
		chk("rx_kept", 8'ha5, v);
		@(posedge i_ref_clk);
		req <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		#1 chk("handoff_off", 8'h00, {7'h00, hand});
		@(posedge i_ref_clk);
		sreq <= 1'b1;
		wait_status(1'b0, 1'b1);
		@(posedge i_ref_clk);
		sreq <= 1'b0;
		rd_i <= 1'b0;
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= `TSI_ADDR_CODES;
		i_wdata <= 8'hc0;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		rd_reg(`TSI_ADDR_CODES, v);
		chk("codes_pending", 8'h80, v);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= `TSI_ADDR_CTRL;
		i_wdata <= 8'h80;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		rd_reg(`TSI_ADDR_STATUS, v);
		chk("soft_reset", 8'h00, v);
		rd_reg(`TSI_ADDR_CODES, v);
		chk("codes_cleared", 8'h00, v);
		wrap_up;
	end
	initial begin
		repeat (96000) @(posedge i_ref_clk);
		mismatches = mismatches + 1;
		wrap_up;
	end
endmodule // tb_teletype_serial_interface
